// *** hw/link_input_bit_allocator.sv ***
`timescale 1ns/100ps

// Behaviour
// RL1 - a word selection of 00, the default, drives no response data onto its input group.
// RL2 - a word selection from 01 to 08 picks response word 1 to 8 as the group's bit source.
// RL3 - four contiguous bits from the start bit (00 to 20) go to link inputs 0 to 3 in order.
// RL4 - the second allocation does the same for link inputs 4 to 7.
// RL5 - with any data allocated both I/O-device alarms follow their faults whatever the detect setting.
// RL6 - the mode digit reads 0 reserved, 1 legacy allocation, 2 link-aware allocation.
// RL7 - in link-aware mode a source digit of 1 takes a link input and 0 a connector pin.
// RL8 - only the two drive prohibits, home switch and two torque limits take link inputs.
// RL9 - allocation and mode settings are latched at restart and never change while running.
module link_input_bit_allocator
  import link_alloc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // link side
  input wire logic [NUM_WORDS-1:0][31:0] response_words_i,
  input wire logic comm_fault_i,
  input wire logic status_fault_i,
  // connector pins
  input wire logic [NUM_PINS-1:0] io_signal_connector_i,
  // link inputs and drive functions
  output logic [7:0] link_seq_input_o,
  output logic forward_drive_prohibit_o,
  output logic reverse_drive_prohibit_o,
  output logic home_switch_o,
  output logic forward_ext_torque_limit_o,
  output logic reverse_ext_torque_limit_o,
  // alarms and interrupt
  output logic io_device_comm_error_alarm_o,
  output logic io_device_status_error_alarm_o,
  output logic irq_o
);

  // software-visible settings
  seq_alloc_s seq_input_alloc_group_a, next_seq_input_alloc_group_a;
  seq_alloc_s seq_input_alloc_group_b, next_seq_input_alloc_group_b;
  logic [15:0] input_alloc_mode_select, next_input_alloc_mode_select;
  func_alloc_s [NUM_FUNCS-1:0] func_alloc, next_func_alloc;
  logic io_device_error_detect_select, next_io_device_error_detect_select;
  logic [EV_WIDTH-1:0] irq_status, next_irq_status;
  logic [EV_WIDTH-1:0] irq_mask, next_irq_mask;
  logic restart_req, next_restart_req;
  logic [31:0] next_dat;
  logic next_ack;

  // settings in force since the last restart
  seq_alloc_s [NUM_GROUPS-1:0] act_alloc, next_act_alloc;
  alloc_mode_e act_mode, next_act_mode;
  func_alloc_s [NUM_FUNCS-1:0] act_func, next_act_func;
  logic act_detect, next_act_detect;

  // outputs
  logic [7:0] next_link_seq;
  logic [NUM_FUNCS-1:0] func_out, next_func_out;
  alarm_s alarm, next_alarm;
  logic next_irq;

  // decode helpers
  logic req;
  logic [13:0] idx;
  logic [NUM_GROUPS-1:0] grp_valid;
  logic [NUM_GROUPS-1:0][BITS_PER_GROUP-1:0] grp_bits;
  logic any_alloc;
  logic [EV_WIDTH-1:0] ev_rise;

  assign req = cyc_i & stb_i & ~ack_o;
  assign idx = adr_i[15:2];

  // extraction of four bits per group from the selected response word
  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g = g + 1) begin : gen_group
      logic [31:0] word;
      logic [31:0] shifted;
      always_comb begin
        grp_valid[g] = (act_alloc[g].word_sel != SEL_NONE)
                       && (act_alloc[g].word_sel <= SEL_MAX)
                       && (act_alloc[g].start <= START_MAX); // see RL1
        word = 32'h0000_0000;
        if (grp_valid[g]) begin
          word = response_words_i[act_alloc[g].word_sel[2:0] - 3'h1]; // see RL2
        end
        shifted = word >> act_alloc[g].start[4:0]; // see RL3
        grp_bits[g] = grp_valid[g] ? shifted[BITS_PER_GROUP-1:0] : 4'h0; // see RL1
      end
    end
  endgenerate

  assign any_alloc = |grp_valid;

  // register writes, reads and interrupt bookkeeping
  always_comb begin
    next_seq_input_alloc_group_a = seq_input_alloc_group_a;
    next_seq_input_alloc_group_b = seq_input_alloc_group_b;
    next_input_alloc_mode_select = input_alloc_mode_select;
    next_func_alloc = func_alloc;
    next_io_device_error_detect_select = io_device_error_detect_select;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_restart_req = 1'b0;
    next_ack = req;
    next_dat = 32'h0000_0000;
    if (req && we_i) begin
      if (idx == IDX_ALLOC_A) begin
        if (sel_i[0]) next_seq_input_alloc_group_a.word_sel = dat_i[7:0];
        if (sel_i[1]) next_seq_input_alloc_group_a.start = dat_i[15:8];
      end
      if (idx == IDX_ALLOC_B) begin
        if (sel_i[0]) next_seq_input_alloc_group_b.word_sel = dat_i[7:0];
        if (sel_i[1]) next_seq_input_alloc_group_b.start = dat_i[15:8];
      end
      if (idx == IDX_MODE) begin
        if (sel_i[0]) next_input_alloc_mode_select[7:0] = dat_i[7:0];
        if (sel_i[1]) next_input_alloc_mode_select[15:8] = dat_i[15:8];
      end
      for (int f = 0; f < NUM_FUNCS; f++) begin
        if (idx == IDX_FUNC_FIRST + 14'(f)) begin
          if (sel_i[0]) next_func_alloc[f][7:0] = dat_i[7:0];
          if (sel_i[1]) next_func_alloc[f][15:8] = dat_i[15:8];
        end
      end
      if (idx == IDX_CTRL && sel_i[0]) begin
        next_restart_req = dat_i[CTRL_RESTART_BIT];
        next_io_device_error_detect_select = dat_i[CTRL_DETECT_BIT];
      end
      if (idx == IDX_IRQ_MASK && sel_i[0]) begin
        next_irq_mask = dat_i[EV_WIDTH-1:0];
      end
    end
    if (req && !we_i) begin
      if (idx == IDX_ALLOC_A) next_dat = {16'h0000, seq_input_alloc_group_a};
      if (idx == IDX_ALLOC_B) next_dat = {16'h0000, seq_input_alloc_group_b};
      if (idx == IDX_MODE) next_dat = {16'h0000, input_alloc_mode_select};
      for (int f = 0; f < NUM_FUNCS; f++) begin
        if (idx == IDX_FUNC_FIRST + 14'(f)) next_dat = {16'h0000, func_alloc[f]};
      end
      if (idx == IDX_CTRL) begin
        next_dat[CTRL_DETECT_BIT] = io_device_error_detect_select;
      end
      if (idx == IDX_IRQ_STATUS) begin
        next_dat[EV_WIDTH-1:0] = irq_status;
        next_irq_status = '0; // read clears
      end
      if (idx == IDX_IRQ_MASK) next_dat[EV_WIDTH-1:0] = irq_mask;
      if (idx == IDX_STATE) begin
        next_dat = {16'h0000, link_seq_input_o, 1'b0, func_out, alarm};
      end
    end
    // a new event beats a clearing read
    next_irq_status = next_irq_status | ev_rise;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_input_alloc_group_a <= ALLOC_RESET;
      seq_input_alloc_group_b <= ALLOC_RESET;
      input_alloc_mode_select <= MODE_RESET;
      func_alloc <= {NUM_FUNCS{FUNC_RESET}};
      io_device_error_detect_select <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      restart_req <= 1'b0;
      dat_o <= 32'h0000_0000;
      ack_o <= 1'b0;
    end else begin
      seq_input_alloc_group_a <= next_seq_input_alloc_group_a;
      seq_input_alloc_group_b <= next_seq_input_alloc_group_b;
      input_alloc_mode_select <= next_input_alloc_mode_select;
      func_alloc <= next_func_alloc;
      io_device_error_detect_select <= next_io_device_error_detect_select;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      restart_req <= next_restart_req;
      dat_o <= next_dat;
      ack_o <= next_ack;
    end
  end

  // working copies are taken only at restart
  always_comb begin
    next_act_alloc = act_alloc;
    next_act_mode = act_mode;
    next_act_func = act_func;
    next_act_detect = act_detect;
    if (restart_req) begin
      next_act_alloc[0] = seq_input_alloc_group_a; // see RL9
      next_act_alloc[1] = seq_input_alloc_group_b; // see RL4
      next_act_func = func_alloc;
      next_act_detect = io_device_error_detect_select;
      case (input_alloc_mode_select[3:0]) // see RL6
        MODE_LINK: next_act_mode = MODE_LINK;
        MODE_LEGACY: next_act_mode = MODE_LEGACY;
        MODE_RESERVED: next_act_mode = MODE_RESERVED;
        default: next_act_mode = MODE_RESERVED;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_alloc <= {NUM_GROUPS{ALLOC_RESET}};
      act_mode <= MODE_LEGACY;
      act_func <= {NUM_FUNCS{FUNC_RESET}};
      act_detect <= 1'b0;
    end else begin
      act_alloc <= next_act_alloc;
      act_mode <= next_act_mode;
      act_func <= next_act_func;
      act_detect <= next_act_detect;
    end
  end

  // link inputs, function routing, alarms and interrupt line
  always_comb begin
    next_link_seq = {grp_bits[1], grp_bits[0]}; // see RL4
    for (int f = 0; f < NUM_FUNCS; f++) begin
      next_func_out[f] = 1'b0;
      case (act_mode)
        MODE_LINK: begin
          if (act_func[f].src == SRC_LINK) begin
            next_func_out[f] = next_link_seq[act_func[f].num[2:0]]; // see RL7
          end else if (act_func[f].src == SRC_PIN) begin
            next_func_out[f] = io_signal_connector_i[act_func[f].num[2:0]]; // see RL7
          end
        end
        MODE_LEGACY: next_func_out[f] = io_signal_connector_i[act_func[f].num[2:0]];
        MODE_RESERVED: next_func_out[f] = 1'b0; // see RL6
        default: next_func_out[f] = 1'b0;
      endcase
      if (act_func[f].num[3]) next_func_out[f] = 1'b0;
    end
    next_alarm.comm_err = comm_fault_i & (act_detect | any_alloc); // see RL5
    next_alarm.status_err = status_fault_i & (act_detect | any_alloc); // see RL5
    ev_rise = {next_alarm.status_err & ~alarm.status_err,
               next_alarm.comm_err & ~alarm.comm_err};
    next_irq = |(irq_status & irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_seq_input_o <= 8'h00;
      func_out <= '0;
      alarm <= '0;
      irq_o <= 1'b0;
    end else begin
      link_seq_input_o <= next_link_seq;
      func_out <= next_func_out;
      alarm <= next_alarm;
      irq_o <= next_irq;
    end
  end

  // only these five functions exist, so nothing else can take a link input
  assign forward_drive_prohibit_o = func_out[0]; // see RL8
  assign reverse_drive_prohibit_o = func_out[1];
  assign home_switch_o = func_out[2];
  assign forward_ext_torque_limit_o = func_out[3];
  assign reverse_ext_torque_limit_o = func_out[4];
  assign io_device_comm_error_alarm_o = alarm.comm_err;
  assign io_device_status_error_alarm_o = alarm.status_err;

endmodule // link_input_bit_allocator

// *** hw/link_alloc_pkg.sv ***
package link_alloc_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_ALLOC_A = 14'h20B1;
  localparam logic [13:0] IDX_ALLOC_B = 14'h20B2;
  localparam logic [13:0] IDX_MODE = 14'h250A;
  localparam logic [13:0] IDX_FUNC_FIRST = 14'h2590;
  localparam logic [13:0] IDX_CTRL = 14'h2600;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h2601;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h2602;
  localparam logic [13:0] IDX_STATE = 14'h2603;

  // counts
  localparam int NUM_WORDS = 8;
  localparam int NUM_GROUPS = 2;
  localparam int BITS_PER_GROUP = 4;
  localparam int NUM_FUNCS = 5;
  localparam int NUM_PINS = 8;

  // response selection and start bit limits
  localparam logic [7:0] SEL_NONE = 8'h00;
  localparam logic [7:0] SEL_MAX = 8'h08;
  localparam logic [7:0] START_MAX = 8'h14;

  // allocation mode digit
  typedef enum logic [3:0] {
    MODE_RESERVED = 4'b0000,
    MODE_LEGACY = 4'b0001,
    MODE_LINK = 4'b0010
  } alloc_mode_e;

  // function source digit
  localparam logic [3:0] SRC_PIN = 4'h0;
  localparam logic [3:0] SRC_LINK = 4'h1;

  // control register bit positions
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_DETECT_BIT = 1;

  // interrupt status bit positions
  localparam int EV_COMM_BIT = 0;
  localparam int EV_STAT_BIT = 1;
  localparam int EV_WIDTH = 2;

  // reset values
  localparam logic [15:0] ALLOC_RESET = 16'h0000;
  localparam logic [15:0] MODE_RESET = 16'h0001;
  localparam logic [15:0] FUNC_RESET = 16'h0000;

  // sequence input allocation: start bit high byte, word select low byte
  typedef struct packed {
    logic [7:0] start;
    logic [7:0] word_sel;
  } seq_alloc_s;

  // function input allocation: source digit then input number
  typedef struct packed {
    logic [7:0] spare;
    logic [3:0] src;
    logic [3:0] num;
  } func_alloc_s;

  // alarm pair
  typedef struct packed {
    logic status_err;
    logic comm_err;
  } alarm_s;

endpackage

// *** tb/link_alloc_sva.sv ***
`timescale 1ns/100ps
module link_alloc_sva
  import link_alloc_pkg::*;
(
  // watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [NUM_WORDS-1:0][31:0] response_words_i,
  input wire logic comm_fault_i,
  input wire logic status_fault_i,
  input wire logic [7:0] link_seq_input_o,
  input wire logic io_device_comm_error_alarm_o,
  input wire logic io_device_status_error_alarm_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // an unanswered request, then a one-cycle answer
  sequence req_s; cyc_i && stb_i && !ack_o; endsequence
  sequence answer_s; ack_o ##1 !ack_o; endsequence
  ack_after_req_a: assert property (req_s |=> answer_s) else $error("ack not single");
  ack_needs_req_a: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  dat_idle_zero_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
  dat_upper_zero_a: assert property (ack_o |-> dat_o[31:16] == 16'h0) else $error("upper half");
  no_data_zero_a: assert property (response_words_i == '0 |=> link_seq_input_o == 8'h00)
    else $error("link inputs without data");
  comm_fault_a: assert property (io_device_comm_error_alarm_o |-> $past(comm_fault_i))
    else $error("comm alarm without fault");
  stat_fault_a: assert property (io_device_status_error_alarm_o |-> $past(status_fault_i))
    else $error("status alarm without fault");
  irq_clear_a: assert property ($fell(irq_o) |-> $past(cyc_i, 1) || $past(cyc_i, 2) || $past(cyc_i, 3))
    else $error("irq fell without access");
endmodule // link_alloc_sva

bind link_input_bit_allocator link_alloc_sva i_link_alloc_sva (.clk_i, .rst_i, .cyc_i, .stb_i,
  .dat_o, .ack_o, .response_words_i, .comm_fault_i, .status_fault_i, .link_seq_input_o,
  .io_device_comm_error_alarm_o, .io_device_status_error_alarm_o, .irq_o);

// *** tb/io_device_model.sv ***
`timescale 1ns/100ps
module io_device_model
  import link_alloc_pkg::*;
(
  // clock and frame request
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic [NUM_WORDS-1:0][31:0] next_words_i,
  input wire logic [1:0] next_faults_i,
  // response words and fault conditions
  output logic [NUM_WORDS-1:0][31:0] response_words_o,
  output logic comm_fault_o,
  output logic status_fault_o
);
  // a new response frame lands on the edge after a request
  always @(posedge clk_i) begin
    if (load_i) begin
      response_words_o <= next_words_i;
      {status_fault_o, comm_fault_o} <= next_faults_i;
    end
  end
  initial {response_words_o, status_fault_o, comm_fault_o} = '0;
endmodule // io_device_model

// *** tb/tb_link_input_bit_allocator.sv ***
`timescale 1ns/100ps
module tb_link_input_bit_allocator
  import link_alloc_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, load = 0;
  logic [15:0] adr_i = 0;
  logic [3:0] sel_i = 4'h3;
  logic [31:0] dat_i = 0, dat_o;
  logic [NUM_WORDS-1:0][31:0] response_words_i, next_words = '0;
  logic [1:0] next_faults = 0;
  logic [7:0] io_signal_connector_i = 0, link_seq_input_o;
  logic ack_o, comm_fault_i, status_fault_i, forward_drive_prohibit_o, reverse_drive_prohibit_o;
  logic home_switch_o, forward_ext_torque_limit_o, reverse_ext_torque_limit_o, irq_o;
  logic io_device_comm_error_alarm_o, io_device_status_error_alarm_o;
  logic [15:0] regs [int], live [int], q, a;
  bit [31:0] mw [8];
  bit [7:0] pm;
  bit [1:0] mf;
  int num_errors = 0, check_count = 0;
  wire [4:0] funcs = {reverse_ext_torque_limit_o, forward_ext_torque_limit_o, home_switch_o,
    reverse_drive_prohibit_o, forward_drive_prohibit_o};
  wire [1:0] alarms = {io_device_status_error_alarm_o, io_device_comm_error_alarm_o};
  link_input_bit_allocator i_link_input_bit_allocator (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .response_words_i, .comm_fault_i, .status_fault_i,
    .io_signal_connector_i, .link_seq_input_o, .forward_drive_prohibit_o,
    .reverse_drive_prohibit_o, .home_switch_o, .forward_ext_torque_limit_o,
    .reverse_ext_torque_limit_o, .io_device_comm_error_alarm_o,
    .io_device_status_error_alarm_o, .irq_o);
  io_device_model i_io_device_model (.clk_i, .load_i(load), .next_words_i(next_words),
    .next_faults_i(next_faults), .response_words_o(response_words_i),
    .comm_fault_o(comm_fault_i), .status_fault_o(status_fault_i));
  initial forever #50 clk_i = ~clk_i;
  // model of one allocation group and of one function source
  function automatic bit ok(input logic [15:0] c);
    return c[7:0] inside {[1:8]} && c[15:8] <= 20;
  endfunction
  function automatic logic [3:0] grp(input logic [15:0] c);
    return ok(c) ? 4'(mw[c[7:0] - 1] >> c[15:8]) : 4'h0;
  endfunction
  function automatic logic fsrc(input logic [15:0] c, input logic [7:0] lk);
    logic [3:0] m;
    m = live[IDX_MODE][3:0];
    if (c[3:0] > 7 || m == 0 || (m == 2 && c[7:4] > 1)) return 1'b0;
    return (m == 2 && c[7:4] == 1) ? lk[c[2:0]] : pm[c[2:0]];
  endfunction
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  // one classic bus cycle, held until ack is sampled
  task automatic wb(input bit w, input logic [13:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, idx, 2'b00, 16'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o[15:0];
    {cyc_i, stb_i, we_i} <= 3'b000;
    if (n >= 20) num_errors++;
    if (w && regs.exists(idx)) regs[idx] = d;
  endtask
  task automatic restart(input bit det);
    wb(1, IDX_CTRL, {14'h0, det, 1'b1});
    live = regs;
    repeat (4) @(posedge clk_i);
  endtask
  // new random response frame and pins, then let outputs settle
  task automatic frame(input bit [1:0] f);
    @(posedge clk_i);
    foreach (mw[i]) begin
      mw[i] = $urandom();
      next_words[i] <= mw[i];
    end
    pm = 8'($urandom());
    mf = f;
    {io_signal_connector_i, next_faults, load} <= {pm, f, 1'b1};
    @(posedge clk_i);
    load <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic chk_all();
    logic [7:0] lk;
    logic [4:0] fx;
    bit en;
    lk = {grp(live[IDX_ALLOC_B]), grp(live[IDX_ALLOC_A])};
    for (int i = 0; i < NUM_FUNCS; i++) fx[i] = fsrc(live[IDX_FUNC_FIRST + i], lk);
    en = ok(live[IDX_ALLOC_A]) || ok(live[IDX_ALLOC_B]) || live[IDX_CTRL][1];
    chk("link inputs", 16'(lk), 16'(link_seq_input_o));
    chk("functions", 16'(fx), 16'(funcs));
    chk("alarms", 16'(mf & {en, en}), 16'(alarms));
    wb(0, IDX_STATE, 0);
    chk("state", {lk, 1'b0, fx, mf & {en, en}}, q);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
  initial begin
    regs[IDX_ALLOC_A] = ALLOC_RESET;
    regs[IDX_ALLOC_B] = ALLOC_RESET;
    regs[IDX_MODE] = MODE_RESET;
    regs[IDX_CTRL] = 16'h0;
    for (int i = 0; i < NUM_FUNCS; i++) regs[IDX_FUNC_FIRST + i] = FUNC_RESET;
    live = regs;
    void'($urandom(78075));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // defaults, unmapped place, write that waits for restart
    wb(0, IDX_MODE, 0);
    chk("mode reset", MODE_RESET, q);
    wb(1, 14'h0100, 16'hFFFF);
    wb(0, 14'h0100, 0);
    chk("unmapped", 16'h0, q);
    wb(1, IDX_ALLOC_A, 16'h0001);
    frame(2'b11);
    chk_all();
    $display("test defaults done");
    // every word select, start bits at and past the limit
    for (int k = 0; k < 11; k++) begin
      a = {8'(k % 3 == 0 ? 0 : k % 3 == 1 ? 20 : $urandom_range(0, 21)), 8'(k < 8 ? k + 1 : (k - 8) * 9)};
      wb(1, IDX_ALLOC_A, a);
      wb(1, IDX_ALLOC_B, {8'($urandom_range(0, 22)), 8'($urandom_range(0, 9))});
      restart(0);
      frame(2'($urandom()));
      chk_all();
    end
    $display("test extraction done");
    // each mode with random function routing
    for (int k = 0; k < 6; k++) begin
      wb(1, IDX_MODE, 16'(k % 3));
      wb(1, IDX_ALLOC_A, {8'($urandom_range(0, 20)), 8'($urandom_range(1, 8))});
      for (int i = 0; i < NUM_FUNCS; i++)
        wb(1, IDX_FUNC_FIRST + 14'(i), {8'h0, 4'($urandom_range(0, 2)), 4'($urandom_range(0, 8))});
      restart(0);
      frame(2'b00);
      chk_all();
    end
    $display("test routing done");
    // interrupt raised, cleared by read, then masked
    wb(1, IDX_IRQ_MASK, 16'h0003);
    wb(0, IDX_IRQ_MASK, 0);
    chk("irq mask", 16'h0003, q);
    frame(2'b11);
    chk("irq raised", 16'h1, {15'h0, irq_o});
    wb(0, IDX_IRQ_STATUS, 0);
    chk("irq status", 16'h0003, q);
    repeat (3) @(posedge clk_i);
    chk("irq cleared", 16'h0, {15'h0, irq_o});
    wb(1, IDX_IRQ_MASK, 0);
    frame(2'b00);
    frame(2'b11);
    chk("irq masked", 16'h0, {15'h0, irq_o});
    wb(0, IDX_IRQ_STATUS, 0);
    chk("irq status masked", 16'h0003, q);
    $display("test interrupt done");
    close_out();
  end
endmodule // tb_link_input_bit_allocator
